// file: bcpm_pkg.sv
// bcpm_pkg: constants for the bridge control upper half and power management capability header
// assumes a config-space access port of dword-aligned byte address, byte enables and read/write strobes
package bcpm_pkg;
   localparam logic [7:0] BCPM_BRIDGE_CTRL_OFS = 8'h3C;
   localparam logic [7:0] BCPM_PM_CAP_OFS = 8'h40;
   localparam int BCPM_VGA_EN_BIT = 19;
   localparam int BCPM_VGA16_BIT = 20;
   localparam int BCPM_SEC_RST_BIT = 22;
   localparam int BCPM_DSI_BIT = 21;
   localparam logic [7:0] BCPM_CAP_ID = 8'h01;
   localparam logic [7:0] BCPM_NEXT_UP = 8'h5C;
   localparam logic [7:0] BCPM_NEXT_DN = 8'h4C;
   localparam logic [2:0] BCPM_PM_REV = 3'h3;
   localparam logic BCPM_DSI_RST = 1'h0;
   localparam logic [2:0] BCPM_AUX_RST = 3'h7;
   localparam logic BCPM_D1_RST = 1'h1;
   localparam logic BCPM_D2_RST = 1'h1;
   localparam logic [4:0] BCPM_PME_SUP_RST = 5'h1F;
   localparam logic [31:0] BCPM_VGA_MEM_LO = 32'h000A_0000;
   localparam logic [31:0] BCPM_VGA_MEM_HI = 32'h000B_FFFF;
   localparam logic [9:0] BCPM_VGA_IO_A_LO = 10'h3B0;
   localparam logic [9:0] BCPM_VGA_IO_A_HI = 10'h3BB;
   localparam logic [9:0] BCPM_VGA_IO_B_LO = 10'h3C0;
   localparam logic [9:0] BCPM_VGA_IO_B_HI = 10'h3DF;
   localparam logic [15:0] BCPM_IO_64K_MASK = 16'hFC00;
   localparam logic [31:0] BCPM_BC_RW_MASK = 32'h0058_0000;
endpackage : bcpm_pkg

// file: bcpm_port_cfg.sv
// bcpm_port_cfg: bridge control bits 31:16 and pm capability header of one switch port
// assumes cfg and preset strobes synchronous to mclk; presets come from the sideband/eeprom loader
`timescale 1ns/1ps
`default_nettype none
module bcpm_port_cfg
   import bcpm_pkg::*;
#(
   parameter bit UPSTREAM = 1'b1,
   parameter int NUM_DN = 2
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire logic preset_wr,
   input wire logic [23:0] preset_data,
   input wire logic acc_valid,
   input wire logic acc_is_io,
   input wire logic [31:0] acc_addr,
   output logic vga_fwd,
   output logic vga_16bit,
   output logic hot_reset,
   output logic [NUM_DN-1:0] port_rst_n
);
   if (NUM_DN < 1) begin : g_bad_num_dn
      $error("bcpm_port_cfg: NUM_DN must be at least 1");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic vga_en;
      logic vga16;
      logic sec_rst;
      logic dsi;
      logic [2:0] aux;
      logic d1;
      logic d2;
      logic [4:0] pme_sup;
      logic [7:0] next_ptr;
      logic [31:0] rdata;
      logic ack;
      logic vga_fwd;
      logic hot_rst;
      logic [NUM_DN-1:0] prst_n;
   } bcpm_state_t;

   bcpm_state_t st_q, st_d;

   function automatic logic [31:0] bcpm_bridge_word(input bcpm_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[BCPM_VGA_EN_BIT] = s.vga_en;
      w[BCPM_VGA16_BIT] = s.vga16;
      w[BCPM_SEC_RST_BIT] = s.sec_rst;
      return w;
   endfunction : bcpm_bridge_word

   function automatic logic [31:0] bcpm_cap_word(input bcpm_state_t s);
      return {s.pme_sup, s.d2, s.d1, s.aux, s.dsi, 1'b0, 1'b0, BCPM_PM_REV, s.next_ptr, BCPM_CAP_ID};
   endfunction : bcpm_cap_word

   // ==========================================================
   // vga range match
   logic io_hit;
   logic [9:0] io_lo;
   assign io_lo = acc_addr[9:0];
   assign io_hit = ((io_lo >= BCPM_VGA_IO_A_LO && io_lo <= BCPM_VGA_IO_A_HI) ||
                    (io_lo >= BCPM_VGA_IO_B_LO && io_lo <= BCPM_VGA_IO_B_HI)) &&
                   (acc_addr[31:16] == 16'h0000) &&
                   (!st_q.vga16 || (acc_addr[15:0] & BCPM_IO_64K_MASK) == 16'h0000);

   // ==========================================================
   // next state
   always_comb begin
      st_d = st_q;
      st_d.ack = cfg_wr | cfg_rd;
      st_d.rdata = 32'h0000_0000;
      if (cfg_rd) begin
         if (cfg_addr == BCPM_BRIDGE_CTRL_OFS) begin
            st_d.rdata = bcpm_bridge_word(st_q);
         end else if (cfg_addr == BCPM_PM_CAP_OFS) begin
            st_d.rdata = bcpm_cap_word(st_q);
         end
      end
      if (cfg_wr && cfg_addr == BCPM_BRIDGE_CTRL_OFS && cfg_be[2]) begin
         st_d.vga_en = cfg_wdata[BCPM_VGA_EN_BIT];
         st_d.vga16 = cfg_wdata[BCPM_VGA16_BIT];
         st_d.sec_rst = cfg_wdata[BCPM_SEC_RST_BIT];
      end
      if (preset_wr) begin
         st_d.next_ptr = preset_data[7:0];
         st_d.dsi = preset_data[13];
         st_d.aux = preset_data[16:14];
         st_d.d1 = preset_data[17];
         st_d.d2 = preset_data[18];
         st_d.pme_sup = preset_data[23:19];
      end
      st_d.vga_fwd = acc_valid && st_q.vga_en &&
                     (acc_is_io ? io_hit : (acc_addr >= BCPM_VGA_MEM_LO && acc_addr <= BCPM_VGA_MEM_HI));
      st_d.hot_rst = st_q.sec_rst;
      st_d.prst_n = '1;
      if (st_q.sec_rst) begin
         if (UPSTREAM) begin
            st_d.prst_n = '0;
         end else begin
            st_d.prst_n[0] = 1'b0;
         end
      end
      if (!nrst) begin
         st_d = '0;
         st_d.dsi = BCPM_DSI_RST;
         st_d.aux = BCPM_AUX_RST;
         st_d.d1 = BCPM_D1_RST;
         st_d.d2 = BCPM_D2_RST;
         st_d.pme_sup = BCPM_PME_SUP_RST;
         st_d.next_ptr = UPSTREAM ? BCPM_NEXT_UP : BCPM_NEXT_DN;
         st_d.prst_n = '1;
      end
   end

   always_ff @(posedge mclk) begin
      st_q <= st_d;
   end

   assign cfg_rdata = st_q.rdata;
   assign cfg_ack = st_q.ack;
   assign vga_fwd = st_q.vga_fwd;
   assign vga_16bit = st_q.vga16;
   assign hot_reset = st_q.hot_rst;
   assign port_rst_n = st_q.prst_n;

   // ==========================================================
   // checks
   sequence s_bc_write;
      cfg_wr && cfg_addr == BCPM_BRIDGE_CTRL_OFS && cfg_be[2];
   endsequence

   sequence s_set_rst;
      cfg_wr && cfg_addr == BCPM_BRIDGE_CTRL_OFS && cfg_be[2] && cfg_wdata[BCPM_SEC_RST_BIT];
   endsequence

   sequence s_clr_rst;
      cfg_wr && cfg_addr == BCPM_BRIDGE_CTRL_OFS && cfg_be[2] && !cfg_wdata[BCPM_SEC_RST_BIT];
   endsequence

   sequence s_cap_write;
      cfg_wr && cfg_addr == BCPM_PM_CAP_OFS && !preset_wr;
   endsequence

   property p_hot_reset_set;
      @(posedge mclk) disable iff (!nrst)
      s_set_rst ##1 nrst |=> hot_reset;
   endproperty
   chk_hot_reset_set: assert property (p_hot_reset_set) else $error("hot reset missing");

   property p_hot_reset_rel;
      @(posedge mclk) disable iff (!nrst)
      s_clr_rst |=> ##1 !hot_reset;
   endproperty
   chk_hot_reset_rel: assert property (p_hot_reset_rel) else $error("hot reset after clear");

   property p_hot_reset_clr;
      @(posedge mclk) disable iff (!nrst)
      !st_q.sec_rst |=> !hot_reset;
   endproperty
   chk_hot_reset_clr: assert property (p_hot_reset_clr) else $error("hot reset without bit");

   property p_dn_port_rst;
      @(posedge mclk) disable iff (!nrst)
      st_q.sec_rst |=> !port_rst_n[0];
   endproperty
   chk_dn_port_rst: assert property (p_dn_port_rst) else $error("port reset missing");

   property p_up_all_rst;
      @(posedge mclk) disable iff (!nrst)
      UPSTREAM && st_q.sec_rst |=> port_rst_n == '0;
   endproperty
   chk_up_all_rst: assert property (p_up_all_rst) else $error("not all ports reset");

   property p_cap_id_rev;
      @(posedge mclk) disable iff (!nrst)
      cfg_rd && cfg_addr == BCPM_PM_CAP_OFS |=> cfg_rdata[7:0] == BCPM_CAP_ID && cfg_rdata[18:16] == BCPM_PM_REV;
   endproperty
   chk_cap_id_rev: assert property (p_cap_id_rev) else $error("cap id or revision wrong");

   property p_legacy_zero;
      @(posedge mclk) disable iff (!nrst)
      cfg_rd && cfg_addr == BCPM_BRIDGE_CTRL_OFS |=> (cfg_rdata & ~BCPM_BC_RW_MASK) == 32'h0000_0000;
   endproperty
   chk_legacy_zero: assert property (p_legacy_zero) else $error("legacy or reserved bits nonzero");

   property p_vga_gate;
      @(posedge mclk) disable iff (!nrst)
      !st_q.vga_en |=> !vga_fwd;
   endproperty
   chk_vga_gate: assert property (p_vga_gate) else $error("vga forwarded while disabled");

   property p_vga_mem_fwd;
      @(posedge mclk) disable iff (!nrst)
      acc_valid && !acc_is_io && st_q.vga_en && acc_addr >= BCPM_VGA_MEM_LO && acc_addr <= BCPM_VGA_MEM_HI
      |=> vga_fwd;
   endproperty
   chk_vga_mem_fwd: assert property (p_vga_mem_fwd) else $error("vga memory access not forwarded");

   property p_vga16_alias;
      @(posedge mclk) disable iff (!nrst)
      acc_valid && acc_is_io && st_q.vga16 && acc_addr[15:10] != 6'h00 |=> !vga_fwd;
   endproperty
   chk_vga16_alias: assert property (p_vga16_alias) else $error("alias forwarded in 16-bit decode");

   property p_vga16_follow;
      @(posedge mclk) disable iff (!nrst)
      s_bc_write |=> vga_16bit == $past(cfg_wdata[BCPM_VGA16_BIT]);
   endproperty
   chk_vga16_follow: assert property (p_vga16_follow) else $error("vga decode width not written");

   property p_next_reset;
      @(posedge mclk)
      !nrst |=> st_q.next_ptr == (UPSTREAM ? BCPM_NEXT_UP : BCPM_NEXT_DN) && st_q.aux == BCPM_AUX_RST &&
         st_q.pme_sup == BCPM_PME_SUP_RST;
   endproperty
   chk_next_reset: assert property (p_next_reset) else $error("capability reset values wrong");

   property p_cap_defaults;
      @(posedge mclk)
      !nrst |=> st_q.dsi == BCPM_DSI_RST && st_q.d1 == BCPM_D1_RST && st_q.d2 == BCPM_D2_RST;
   endproperty
   chk_cap_defaults: assert property (p_cap_defaults) else $error("power state support defaults wrong");

   property p_cap_write_ro;
      @(posedge mclk) disable iff (!nrst)
      s_cap_write |=> $stable(st_q.next_ptr) && $stable(st_q.aux) && $stable(st_q.pme_sup) &&
         $stable(st_q.dsi) && $stable(st_q.d1) && $stable(st_q.d2);
   endproperty
   chk_cap_write_ro: assert property (p_cap_write_ro) else $error("read-only field changed by write");

   property p_preset_load;
      @(posedge mclk) disable iff (!nrst)
      preset_wr |=> st_q.next_ptr == $past(preset_data[7:0]) && st_q.pme_sup == $past(preset_data[23:19]);
   endproperty
   chk_preset_load: assert property (p_preset_load) else $error("preset not loaded");
endmodule : bcpm_port_cfg
`default_nettype wire

// file: bcpm_host.sv
// bcpm_host: host side model issuing config reads and writes
// assumes strobes are taken at the next rising mclk
`timescale 1ns/1ps
`default_nettype none
module bcpm_host (
   input wire logic mclk,
   output logic cfg_wr = 1'b0,
   output logic cfg_rd = 1'b0,
   output logic [7:0] cfg_addr = 8'h00,
   output logic [3:0] cfg_be = 4'hF,
   output logic [31:0] cfg_wdata = 32'h0
);
   // ==========================================
   // one access, released with inverted lines
   task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      cfg_wr <= wr;
      cfg_rd <= !wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
      #1;
   endtask : acc
endmodule : bcpm_host
`default_nettype wire

// file: bcpm_port_cfg_bench.sv
// bcpm_port_cfg_bench: upstream and downstream ports sharing one host
// assumes bcpm_host drives the config strobes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module bcpm_port_cfg_bench;
   import bcpm_pkg::*;
   typedef struct packed {logic [31:0] bc; logic io; logic [31:0] a; logic fwd;} bcpm_row_t;
   localparam bcpm_row_t ROWS [10] = '{'{32'h0, 1'b0, 32'h000A0000, 1'b0},
      '{32'h00080000, 1'b0, 32'h000A0000, 1'b1}, '{32'h00080000, 1'b0, 32'h000BFFFF, 1'b1},
      '{32'h00080000, 1'b0, 32'h000C0000, 1'b0}, '{32'h00080000, 1'b1, 32'h000003BB, 1'b1},
      '{32'h00080000, 1'b1, 32'h000003BC, 1'b0}, '{32'h00080000, 1'b1, 32'h000013DF, 1'b1},
      '{32'h00180000, 1'b1, 32'h000013DF, 1'b0}, '{32'h00180000, 1'b1, 32'h000003C0, 1'b1},
      '{32'h00080000, 1'b1, 32'h000103C0, 1'b0}};
   logic mclk = 1'b0, nrst = 1'b0, cfg_wr, cfg_rd, cfg_ack, preset_wr = 1'b0, acc_valid = 1'b0;
   logic acc_is_io = 1'b0, vga_fwd, vga_16bit, hot_reset, hot_dn;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, rdata_dn, acc_addr = 32'h0;
   logic [23:0] preset_data = 24'h0;
   logic [1:0] port_rst_n, rst_dn;
   int error_cnt = 0, samples_checked = 0, cyc = 0;
   always #5 mclk = ~mclk;
   bcpm_host i_host (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
   bcpm_port_cfg #(.UPSTREAM(1'b1), .NUM_DN(2)) i_dut (.mclk, .nrst, .cfg_wr, .cfg_rd, .cfg_addr,
      .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .preset_wr, .preset_data, .acc_valid, .acc_is_io,
      .acc_addr, .vga_fwd, .vga_16bit, .hot_reset, .port_rst_n);
   bcpm_port_cfg #(.UPSTREAM(1'b0), .NUM_DN(2)) i_dn (.mclk, .nrst, .cfg_wr, .cfg_rd, .cfg_addr,
      .cfg_be, .cfg_wdata, .cfg_rdata(rdata_dn), .cfg_ack(), .preset_wr, .preset_data, .acc_valid,
      .acc_is_io, .acc_addr, .vga_fwd(), .vga_16bit(), .hot_reset(hot_dn), .port_rst_n(rst_dn));
   // ==========================================
   // closing report and hang limit
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim;
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      `CHK("rst_n", 2'b11, port_rst_n)
      `CHK("vga16_rst", 1'b0, vga_16bit)
      `CHK("hot_rst", 1'b0, hot_reset)
      i_host.acc(1'b0, BCPM_PM_CAP_OFS, 32'h0);
      `CHK("ack", 1'b1, cfg_ack)
      `CHK("cap_up", 32'hFFC35C01, cfg_rdata)
      `CHK("cap_dn", 32'hFFC34C01, rdata_dn)
      foreach (ROWS[i]) begin
         i_host.acc(1'b1, BCPM_BRIDGE_CTRL_OFS, ROWS[i].bc);
         @(posedge mclk);
         acc_valid <= 1'b1;
         acc_is_io <= ROWS[i].io;
         acc_addr <= ROWS[i].a;
         @(posedge mclk);
         acc_valid <= 1'b0;
         #1;
         `CHK("vga_fwd", ROWS[i].fwd, vga_fwd)
         `CHK("vga16", ROWS[i].bc[20], vga_16bit)
      end
      i_host.acc(1'b1, BCPM_BRIDGE_CTRL_OFS, 32'hFFFFFFFF);
      @(posedge mclk);
      #1;
      `CHK("hot", 1'b1, hot_reset)
      `CHK("hot_dn", 1'b1, hot_dn)
      `CHK("rst_up", 2'b00, port_rst_n)
      `CHK("rst_dn", 2'b10, rst_dn)
      i_host.acc(1'b0, BCPM_BRIDGE_CTRL_OFS, 32'h0);
      `CHK("bc", 32'h00580000, cfg_rdata)
      i_host.acc(1'b1, BCPM_BRIDGE_CTRL_OFS, 32'h0);
      @(posedge mclk);
      #1;
      `CHK("rel", 2'b11, port_rst_n)
      i_host.acc(1'b1, BCPM_PM_CAP_OFS, 32'h0);
      i_host.acc(1'b0, BCPM_PM_CAP_OFS, 32'h0);
      `CHK("cap_ro", 32'hFFC35C01, cfg_rdata)
      i_host.acc(1'b0, 8'h44, 32'h0);
      `CHK("unmapped", 32'h0, cfg_rdata)
      @(posedge mclk);
      preset_wr <= 1'b1;
      preset_data <= 24'h201F10;
      @(posedge mclk);
      preset_wr <= 1'b0;
      i_host.acc(1'b0, BCPM_PM_CAP_OFS, 32'h0);
      `CHK("preset", 32'h20031001, cfg_rdata)
      i_host.acc(1'b1, BCPM_BRIDGE_CTRL_OFS, 32'h00500000);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      `CHK("vga16_mid", 1'b0, vga_16bit)
      `CHK("hot_mid", 1'b0, hot_reset)
      `CHK("rst_up_mid", 2'b11, port_rst_n)
      `CHK("rst_dn_mid", 2'b11, rst_dn)
      i_host.acc(1'b0, BCPM_PM_CAP_OFS, 32'h0);
      `CHK("cap_mid", 32'hFFC35C01, cfg_rdata)
      `CHK("cap_dn_mid", 32'hFFC34C01, rdata_dn)
      end_sim;
   end
endmodule : bcpm_port_cfg_bench
`default_nettype wire
